// ### core/cslt_pkg.sv
// Shared constants and types for the converter serial link transmitter.
// Assumes a single 200 MHz sample clock and byte-wide register access.
package cslt_pkg;
  // Register offsets
  localparam logic [7:0] REG_QUICK_CFG = 8'h5e;
  localparam logic [7:0] REG_LINK_CTL1 = 8'h60;
  localparam logic [7:0] REG_LINK_CTL2 = 8'h61;
  localparam logic [7:0] REG_SCR_LANE = 8'h6e;
  localparam logic [7:0] REG_LINK_STAT = 8'h6f;
  // Reset values
  localparam logic [7:0] QUICK_CFG_RST = 8'h00;
  localparam logic [7:0] LINK_CTL1_RST = 8'h00;
  localparam logic [7:0] LINK_CTL2_RST = 8'h00;
  localparam logic [7:0] SCR_LANE_RST = 8'h00;
  localparam logic [14:0] SCR_SEED_RST = 15'h0000;
  // Field positions
  localparam int CTL1_TAIL_BIT = 6;
  localparam int CTL1_ILAS_HI = 3;
  localparam int CTL1_ILAS_LO = 2;
  localparam int CTL2_CMOS_BIT = 4;
  localparam int SCR_EN_BIT = 7;
  localparam int QUICK_MODE_HI = 1;
  // Link and lane configurations in the quick configuration field
  localparam logic [1:0] MODE_TWO_LINK = 2'h0;
  localparam logic [1:0] MODE_ONE_LINK = 2'h1;
  localparam logic [1:0] MODE_ONE_LANE = 2'h2;
  // Octets per frame, frames per multiframe and alignment multiframes less one; sync low cycles
  localparam logic [1:0] F_LAST_DUAL = 2'h1;
  localparam logic [1:0] F_LAST_SINGLE = 2'h3;
  localparam logic [3:0] K_LAST_TWO_LANE = 4'hf;
  localparam logic [3:0] K_LAST_ONE_LANE = 4'h7;
  localparam logic [2:0] ILAS_MF_LAST = 3'h3;
  localparam logic [1:0] SYNC_LOW_MIN = 2'h2;
  // Control characters
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;

  typedef enum logic [1:0] {CSLT_CGS, CSLT_ILAS, CSLT_DATA} cslt_link_t;

  typedef struct packed {
    logic ovr_b;
    logic [13:0] smp_b;
    logic ovr_a;
    logic [13:0] smp_a;
  } cslt_pair_t;
endpackage

// ### core/cslt_enc8b10b.sv
// Combinational 8b/10b encoder for one lane; bit 9 of the code is sent first.
// Assumes the caller registers the code and the running disparity.
`timescale 1ns/100ps
`default_nettype none
module cslt_enc8b10b (
  input wire logic [7:0] oct,
  input wire logic is_k,
  input wire logic rd_in,
  output logic [9:0] code,
  output logic rd_out
);
  logic [5:0] c6;
  logic [3:0] c4;
  logic [3:0] k4;
  logic rd_mid;
  logic alt;

  always_comb
  begin
    case (oct[4:0])
      5'h00: c6 = 6'b100111;  5'h01: c6 = 6'b011101;  5'h02: c6 = 6'b101101;
      5'h03: c6 = 6'b110001;  5'h04: c6 = 6'b110101;  5'h05: c6 = 6'b101001;
      5'h06: c6 = 6'b011001;  5'h07: c6 = 6'b111000;  5'h08: c6 = 6'b111001;
      5'h09: c6 = 6'b100101;  5'h0a: c6 = 6'b010101;  5'h0b: c6 = 6'b110100;
      5'h0c: c6 = 6'b001101;  5'h0d: c6 = 6'b101100;  5'h0e: c6 = 6'b011100;
      5'h0f: c6 = 6'b010111;  5'h10: c6 = 6'b011011;  5'h11: c6 = 6'b100011;
      5'h12: c6 = 6'b010011;  5'h13: c6 = 6'b110010;  5'h14: c6 = 6'b001011;
      5'h15: c6 = 6'b101010;  5'h16: c6 = 6'b011010;  5'h17: c6 = 6'b111010;
      5'h18: c6 = 6'b110011;  5'h19: c6 = 6'b100110;  5'h1a: c6 = 6'b010110;
      5'h1b: c6 = 6'b110110;  5'h1c: c6 = 6'b001110;  5'h1d: c6 = 6'b101110;
      5'h1e: c6 = 6'b011110;  default: c6 = 6'b101011;
    endcase
    case (oct[7:5])
      3'h0: c4 = 4'b1011;  3'h1: c4 = 4'b1001;  3'h2: c4 = 4'b0101;  3'h3: c4 = 4'b1100;
      3'h4: c4 = 4'b1101;  3'h5: c4 = 4'b1010;  3'h6: c4 = 4'b0110;  default: c4 = 4'b1110;
    endcase
    // Only K28.y is ever sent as a control symbol, so one column suffices
    case (oct[7:5])
      3'h0: k4 = 4'b0100;  3'h1: k4 = 4'b1001;  3'h2: k4 = 4'b0101;  3'h3: k4 = 4'b0011;
      3'h4: k4 = 4'b0010;  3'h5: k4 = 4'b1010;  3'h6: k4 = 4'b0110;  default: k4 = 4'b1000;
    endcase
    rd_mid = rd_in ^ ($countones(c6) != 3);
    if (rd_in && (($countones(c6) != 3) || (oct[4:0] == 5'h07)))
      c6 = ~c6;
    // Alternate D.x.7 keeps the run length of five within bounds
    alt = (oct[7:5] == 3'h7) &&
      ((!rd_mid && (oct[4:0] == 5'h11 || oct[4:0] == 5'h12 || oct[4:0] == 5'h14)) ||
       (rd_mid && (oct[4:0] == 5'h0b || oct[4:0] == 5'h0d || oct[4:0] == 5'h0e)));
    if (alt)
      c4 = 4'b0111;
    if (rd_mid && (($countones(c4) != 2) || (oct[7:5] == 3'h3)))
      c4 = ~c4;
    if (is_k)
      code = rd_in ? ~{6'b001111, k4} : {6'b001111, k4};
    else
      code = {c6, c4};
    rd_out = rd_in ^ ($countones(code) != 5);
  end
endmodule
`default_nettype wire

// ### core/cslt_tx.sv
// Transmit side of a two-lane converter serial link: framing, scrambling,
// alignment characters and 8b/10b coding. Assumes sync inputs already
// synchronous to clk and a serializer that shifts each code out bit 9 first.
// Functional notes
// - Sample bits 13:6 form octet one; bits 5:0 plus two tail bits octet two.
// - Link control one bit 6 lets the upper tail bit flag out of range.
// - Scramble octets only while scrambler enable bit 7 of 0x6e is set.
// - Scrambler is self-synchronising with polynomial 1 + x^14 + x^15.
// - Every octet becomes one 10-bit 8b/10b symbol.
// - Sync request low two cycles starts K28.5 comma stream until released.
// - On release run lane alignment if enabled by 0x60 bits 3:2, then data.
// - First symbol after the commas is the first octet of a frame.
// - Sync input is differential unless link_control_two bit 4 selects CMOS.
// - Unscrambled repeated frame end becomes K28.7, or K28.3 at multiframe end with lane sync.
// - Scrambled multiframe end equal to 0x7c becomes K28.3 with lane sync.
// - Scrambled frame end equal to 0xfc becomes K28.7 when not multiframe end.
// - Default: two links, one converter and lane each, F=2, fourteen bit samples.
// - Single lane mode: both converters on lane A, F=4, K=8, A first.
// - Single link mode: two lanes, K=16, both driven from link A sync.
// - Quick configuration register quick_link_config selects the link configuration.
// - Each link has its own sync request and synchronisation state.
// - Control bits 0 or 1 per sample, no control words, no dense packing.
// - Each 10-bit symbol is sent most significant bit first.
`timescale 1ns/100ps
`default_nettype none
module cslt_tx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic in_valid,
  input wire cslt_pkg::cslt_pair_t in_pair,
  output logic in_ready,
  input wire logic [1:0] lane_sync_request_diff,
  input wire logic [1:0] lane_sync_request_cmos,
  output logic [1:0][9:0] lane_sym,
  output logic sym_valid,
  input wire logic sym_ready
);
  typedef struct packed {
    cslt_pkg::cslt_pair_t [1:0] buf_q;
    logic [1:0] buf_cnt;
    logic in_rdy;
    logic [7:0] quick;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] scr_cfg;
    logic [7:0] rdata;
    cslt_pkg::cslt_link_t [1:0] lst;
    logic [1:0][1:0] low_cnt;
    logic [1:0][3:0] fcnt;
    logic [1:0][2:0] mfcnt;
    logic [1:0] oidx;
    logic [1:0][14:0] scrambler_on;
    logic [1:0][7:0] last_oct;
    logic [1:0] rd;
    logic [1:0][9:0] sym;
    logic sym_vld;
  } cslt_state_t;

  localparam cslt_state_t ST_RST = '{quick: cslt_pkg::QUICK_CFG_RST,
    ctl1: cslt_pkg::LINK_CTL1_RST, ctl2: cslt_pkg::LINK_CTL2_RST,
    scr_cfg: cslt_pkg::SCR_LANE_RST,
    scrambler_on: {2{cslt_pkg::SCR_SEED_RST}}, default: '0};

  cslt_state_t s_reg;
  cslt_state_t s_next;
  logic [1:0] mode;
  logic one_lane;
  logic lanesync;
  logic scr_on;
  logic [1:0] f_lastidx;
  logic f_last;
  logic [3:0] kmax;
  logic go;
  logic [1:0] sync_sel;
  logic [9:0] l_code [2];
  logic l_rd [2];
  logic [7:0] l_oct [2];
  logic l_k [2];
  logic [14:0] l_scr [2];
  logic [7:0] l_raw [2];
  logic l_data [2];

  // Scrambler shifts in its own output bits, so the receiver self-synchronises
  function automatic logic [22:0] scramble_octet(input logic [7:0] d, input logic [14:0] st);
    logic [14:0] x;
    logic [7:0] o;
    x = st;
    o = '0;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ x[14] ^ x[13];
      x = {x[13:0], o[i]};
    end
    return {o, x};
  endfunction

  assign mode = s_reg.quick[cslt_pkg::QUICK_MODE_HI:0];
  assign one_lane = (mode == cslt_pkg::MODE_ONE_LANE);
  assign lanesync = |s_reg.ctl1[cslt_pkg::CTL1_ILAS_HI:cslt_pkg::CTL1_ILAS_LO];
  assign scr_on = s_reg.scr_cfg[cslt_pkg::SCR_EN_BIT];
  assign f_lastidx = one_lane ? cslt_pkg::F_LAST_SINGLE : cslt_pkg::F_LAST_DUAL;
  assign f_last = (s_reg.oidx == f_lastidx);
  assign kmax = one_lane ? cslt_pkg::K_LAST_ONE_LANE : cslt_pkg::K_LAST_TWO_LANE;
  // A frame cannot start without a sample, so an empty buffer stalls the lanes
  assign go = (!s_reg.sym_vld || sym_ready) && (s_reg.oidx != 2'h0 || s_reg.buf_cnt != 2'h0);
  assign sync_sel = s_reg.ctl2[cslt_pkg::CTL2_CMOS_BIT] ? lane_sync_request_cmos
    : lane_sync_request_diff;

  for (genvar l = 0; l < 2; l++)
  begin : g_lane
    cslt_pkg::cslt_link_t st;
    cslt_pkg::cslt_pair_t pr;
    logic [3:0] fc;
    logic [2:0] mc;
    logic half_b;
    logic [13:0] smp;
    logic ovr;
    logic mf_end;
    logic [22:0] sv;

    always_comb
    begin
      // Lane B follows link A in single link mode and idles in single lane mode
      st = (l == 0 || mode != cslt_pkg::MODE_TWO_LINK) ? s_reg.lst[0] : s_reg.lst[1];
      fc = (l == 0 || mode != cslt_pkg::MODE_TWO_LINK) ? s_reg.fcnt[0] : s_reg.fcnt[1];
      mc = (l == 0 || mode != cslt_pkg::MODE_TWO_LINK) ? s_reg.mfcnt[0] : s_reg.mfcnt[1];
      if (l == 1 && one_lane)
        st = cslt_pkg::CSLT_CGS;
      pr = s_reg.buf_q[0];
      half_b = one_lane ? s_reg.oidx[1] : (l == 1);
      smp = half_b ? pr.smp_b : pr.smp_a;
      ovr = half_b ? pr.ovr_b : pr.ovr_a;
      // Upper tail bit carries out of range only when enabled; lower is zero
      l_raw[l] = s_reg.oidx[0] ? {smp[5:0], s_reg.ctl1[cslt_pkg::CTL1_TAIL_BIT] & ovr, 1'b0}
        : smp[13:6];
      mf_end = lanesync && f_last && (fc == kmax);
      sv = scramble_octet(l_raw[l], s_reg.scrambler_on[l]);
      l_oct[l] = l_raw[l];
      l_k[l] = 1'b0;
      l_scr[l] = s_reg.scrambler_on[l];
      l_data[l] = 1'b0;
      case (st)
        cslt_pkg::CSLT_CGS:
        begin
          l_oct[l] = cslt_pkg::K28_5;
          l_k[l] = 1'b1;
        end
        cslt_pkg::CSLT_ILAS:
        begin
          l_k[l] = 1'b1;
          if (fc == 4'h0 && s_reg.oidx == 2'h0)
            l_oct[l] = cslt_pkg::K28_0;
          else if (f_last && fc == kmax)
            l_oct[l] = cslt_pkg::K28_3;
          else
          begin
            l_k[l] = 1'b0;
            l_oct[l] = {mc[1:0], fc, s_reg.oidx};
          end
        end
        default:
        begin
          l_data[l] = 1'b1;
          if (scr_on)
          begin
            l_oct[l] = sv[22:15];
            l_scr[l] = sv[14:0];
            if (mf_end && sv[22:15] == cslt_pkg::K28_3)
              l_k[l] = 1'b1;
            else if (f_last && !mf_end && sv[22:15] == cslt_pkg::K28_7)
              l_k[l] = 1'b1;
          end
          else if (f_last && l_raw[l] == s_reg.last_oct[l])
          begin
            l_k[l] = 1'b1;
            l_oct[l] = mf_end ? cslt_pkg::K28_3 : cslt_pkg::K28_7;
          end
        end
      endcase
    end

    cslt_enc8b10b u_enc (
      .oct(l_oct[l]),
      .is_k(l_k[l]),
      .rd_in(s_reg.rd[l]),
      .code(l_code[l]),
      .rd_out(l_rd[l])
    );
  end

  always_comb
  begin
    logic pop;
    logic push;
    logic [1:0] cnt_mid;
    logic rel;
    s_next = s_reg;
    rel = 1'b0;
    pop = go && f_last;
    push = in_valid && s_reg.in_rdy;
    // Two-entry buffer: a stalled serializer holds words here, never drops them
    cnt_mid = s_reg.buf_cnt - {1'b0, pop};
    if (pop)
      s_next.buf_q[0] = s_reg.buf_q[1];
    if (push)
      s_next.buf_q[cnt_mid[0]] = in_pair;
    s_next.buf_cnt = cnt_mid + {1'b0, push};
    s_next.in_rdy = (s_next.buf_cnt != 2'h2);
    if (reg_wr)
    begin
      if (reg_addr == cslt_pkg::REG_QUICK_CFG)
        s_next.quick = reg_wdata;
      else if (reg_addr == cslt_pkg::REG_LINK_CTL1)
        s_next.ctl1 = reg_wdata;
      else if (reg_addr == cslt_pkg::REG_LINK_CTL2)
        s_next.ctl2 = reg_wdata;
      else if (reg_addr == cslt_pkg::REG_SCR_LANE)
        s_next.scr_cfg = reg_wdata;
    end
    if (reg_addr == cslt_pkg::REG_QUICK_CFG)
      s_next.rdata = s_reg.quick;
    else if (reg_addr == cslt_pkg::REG_LINK_CTL1)
      s_next.rdata = s_reg.ctl1;
    else if (reg_addr == cslt_pkg::REG_LINK_CTL2)
      s_next.rdata = s_reg.ctl2;
    else if (reg_addr == cslt_pkg::REG_SCR_LANE)
      s_next.rdata = s_reg.scr_cfg;
    else if (reg_addr == cslt_pkg::REG_LINK_STAT)
      s_next.rdata = {2'h0, s_reg.buf_cnt, 2'(s_reg.lst[1]), 2'(s_reg.lst[0])};
    else
      s_next.rdata = 8'h00;

    // Each link keeps its own sync filter and state
    for (int k = 0; k < 2; k++)
    begin
      rel = sync_sel[k];
      s_next.low_cnt[k] = rel ? 2'h0
        : (s_reg.low_cnt[k] == cslt_pkg::SYNC_LOW_MIN ? s_reg.low_cnt[k] : s_reg.low_cnt[k] + 2'h1);
      if (!rel && s_next.low_cnt[k] == cslt_pkg::SYNC_LOW_MIN)
      begin
        s_next.lst[k] = cslt_pkg::CSLT_CGS;
        s_next.fcnt[k] = 4'h0;
        s_next.mfcnt[k] = 3'h0;
      end
      else if (go && f_last)
      begin
        // State changes land on a frame boundary so the next octet starts a frame
        case (s_reg.lst[k])
          cslt_pkg::CSLT_CGS:
            if (rel)
              s_next.lst[k] = lanesync ? cslt_pkg::CSLT_ILAS : cslt_pkg::CSLT_DATA;
          cslt_pkg::CSLT_ILAS:
          begin
            s_next.fcnt[k] = (s_reg.fcnt[k] == kmax) ? 4'h0 : s_reg.fcnt[k] + 4'h1;
            if (s_reg.fcnt[k] == kmax)
            begin
              s_next.mfcnt[k] = s_reg.mfcnt[k] + 3'h1;
              if (s_reg.mfcnt[k] == cslt_pkg::ILAS_MF_LAST)
                s_next.lst[k] = cslt_pkg::CSLT_DATA;
            end
          end
          default:
            s_next.fcnt[k] = (s_reg.fcnt[k] == kmax) ? 4'h0 : s_reg.fcnt[k] + 4'h1;
        endcase
      end
    end

    if (go)
    begin
      for (int l = 0; l < 2; l++)
      begin
        s_next.sym[l] = l_code[l];
        s_next.rd[l] = l_rd[l];
        if (l_data[l] && scr_on)
          s_next.scrambler_on[l] = l_scr[l];
        if (l_data[l] && f_last)
          s_next.last_oct[l] = l_raw[l];
      end
      s_next.sym_vld = 1'b1;
      s_next.oidx = f_last ? 2'h0 : s_reg.oidx + 2'h1;
    end
    else if (sym_ready)
      s_next.sym_vld = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_reg <= ST_RST;
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign in_ready = s_reg.in_rdy;
  assign lane_sym = s_reg.sym;
  assign sym_valid = s_reg.sym_vld;

  localparam logic [9:0] SYM_K285_NEG = 10'h0fa;
  localparam logic [9:0] SYM_K285_POS = 10'h305;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_sync_low;
    !sync_sel[0] ##1 !sync_sel[0];
  endsequence
  sequence s_cgs_exit;
    (s_reg.lst[0] == cslt_pkg::CSLT_CGS) ##1 (s_reg.lst[0] != cslt_pkg::CSLT_CGS);
  endsequence

  property p_sync_low;
    s_sync_low |=> (s_reg.lst[0] == cslt_pkg::CSLT_CGS);
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("link A not in comma state");

  property p_comma;
    (go && s_reg.lst[0] == cslt_pkg::CSLT_CGS)
      |=> (lane_sym[0] == SYM_K285_NEG || lane_sym[0] == SYM_K285_POS);
  endproperty
  a_comma: assert property (p_comma) else $error("comma stream symbol wrong");

  property p_frame_start;
    s_cgs_exit |-> (s_reg.oidx == 2'h0);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not aligned");

  property p_ilas_on;
    (s_reg.lst[0] == cslt_pkg::CSLT_CGS && sync_sel[0] && go && f_last && lanesync)
      |=> (s_reg.lst[0] == cslt_pkg::CSLT_ILAS);
  endproperty
  a_ilas_on: assert property (p_ilas_on) else $error("alignment not started");

  property p_ilas_off;
    (s_reg.lst[0] == cslt_pkg::CSLT_CGS && sync_sel[0] && go && f_last && !lanesync)
      |=> (s_reg.lst[0] == cslt_pkg::CSLT_DATA);
  endproperty
  a_ilas_off: assert property (p_ilas_off) else $error("data not started");

  property p_disparity;
    go |=> (s_reg.rd[0] == ($past(s_reg.rd[0]) ^ ($countones(lane_sym[0]) != 5)));
  endproperty
  a_disparity: assert property (p_disparity) else $error("disparity not tracked");

  property p_scr_idle;
    !scr_on |=> $stable(s_reg.scrambler_on[0]);
  endproperty
  a_scr_idle: assert property (p_scr_idle) else $error("scrambler ran while off");

  property p_one_lane;
    (go && one_lane)
      |=> (lane_sym[1] == SYM_K285_NEG || lane_sym[1] == SYM_K285_POS);
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("lane B active in one lane mode");

  property p_full;
    (s_reg.buf_cnt == 2'h2) |-> !in_ready ##1 (s_reg.buf_cnt != 2'h0);
  endproperty
  a_full: assert property (p_full) else $error("buffer accepted while full");
endmodule
`default_nettype wire

// ### test/cslt_rx_model.sv
// Receiver partner: queues each taken symbol pair and answers a comma
// stream by releasing its sync request. Assumes bench drives resync/stall.
`timescale 1ns/100ps
`default_nettype none
module cslt_rx_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0][9:0] lane_sym,
  input wire logic sym_valid,
  output logic sym_ready,
  output logic [1:0] sync_n,
  input wire logic [1:0] resync,
  input wire logic stall,
  input wire logic slow
);
  logic [9:0] qa[$];
  logic [9:0] qb[$];
  int seen [2];
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      sym_ready <= 1'b0;
      sync_n <= 2'h3;
      seen <= '{0, 0};
    end
    else
    begin
      // Alternating ready exercises the hold side of the handshake
      sym_ready <= !stall && (!slow || !sym_ready);
      if (sym_valid && sym_ready)
      begin
        qa.push_back(lane_sym[0]);
        qb.push_back(lane_sym[1]);
      end
      for (int l = 0; l < 2; l++)
      begin
        if (resync[l])
        begin
          sync_n[l] <= 1'b0;
          seen[l] <= 0;
        end
        else if (!sync_n[l] && sym_valid && sym_ready && lane_sym[l] inside {10'h0fa, 10'h305})
        begin
          seen[l] <= seen[l] + 1;
          if (seen[l] == 3)
            sync_n[l] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_cslt_tx.sv
// Self-checking bench for the link transmitter: registers, sync, framing,
// alignment characters, scrambling, modes, buffering. Assumes rx partner.
`timescale 1ns/100ps
`default_nettype none
module tb_cslt_tx;
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, in_valid = 1'b0, scrambler_on = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  cslt_pkg::cslt_pair_t in_pair = '0;
  logic in_ready, sym_valid, sym_ready;
  logic stall = 1'b0, slow = 1'b0, diff_kill = 1'b0;
  logic [1:0] sync_n, resync = 2'h0;
  wire logic [1:0] sync_diff;
  logic [1:0][9:0] lane_sym;
  int failures = 0, checked = 0, cycles = 0, ils = 0;
  logic [7:0] prev [2] = '{8'h00, 8'h00};
  logic [14:0] st [2] = '{15'h0000, 15'h0000};
  logic [7:0] expq [2][$];
  cslt_pkg::cslt_pair_t pq[$];
  always #2.5 clk = ~clk;
  // Forcing the differential copy low proves which path is listened to
  assign sync_diff = sync_n & ~{2{diff_kill}};
  cslt_tx cslt_tx_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_pair(in_pair),
    .in_ready(in_ready), .lane_sync_request_diff(sync_diff), .lane_sync_request_cmos(sync_n),
    .lane_sym(lane_sym), .sym_valid(sym_valid), .sym_ready(sym_ready));
  cslt_rx_model cslt_rx_model_i (.clk(clk), .nrst(nrst), .lane_sym(lane_sym),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .sync_n(sync_n), .resync(resync),
    .stall(stall), .slow(slow));
  task automatic stop_test;
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 cmp("reg_rdata", {2'h0, exp}, {2'h0, reg_rdata});
  endtask
  // Decodes a data code of either disparity; bit 8 flags a valid code
  function automatic logic [8:0] dec(input logic [9:0] c);
    logic [8:0] r;
    logic hx, hy;
    r = 9'h000;
    hx = 1'b0;
    hy = 1'b0;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 32; i++)
        if (!hx && c[9:4] == (p ? ~T6[i] : T6[i]))
        begin
          r[4:0] = 5'(i);
          hx = 1'b1;
        end
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
        if (!hy && c[3:0] == (p ? ~T4[i] : T4[i]))
        begin
          r[7:5] = 3'(i);
          hy = 1'b1;
        end
    if (!hy && (c[3:0] == 4'h7 || c[3:0] == 4'h8))
    begin
      r[7:5] = 3'h7;
      hy = 1'b1;
    end
    r[8] = hx && hy;
    return r;
  endfunction
  function automatic cslt_pkg::cslt_pair_t mk(input int i);
    cslt_pkg::cslt_pair_t p;
    p.smp_a = 14'(i * 14'h18d + 14'h64);
    p.smp_b = 14'(i * 14'hd3 + 14'hbb8);
    p.ovr_a = i[0];
    p.ovr_b = i[1];
    return p;
  endfunction
  task automatic chk(input int l, input int f, input int cmax);
    logic [9:0] q[$];
    logic [8:0] d;
    logic [7:0] o;
    logic k, b, k3;
    logic [9:0] em;
    bit mfe;
    int c;
    q = l ? cslt_rx_model_i.qb : cslt_rx_model_i.qa;
    c = 0;
    while (c < q.size() && q[c] inside {10'h0fa, 10'h305})
    begin
      if (c > 0)
        cmp("comma code", ~q[c - 1], q[c]);
      c++;
    end
    if (expq[l].size() == 0)
    begin
      cmp("idle lane commas", 10'(q.size()), 10'(c));
      return;
    end
    cmp("comma frame end", 10'h000, 10'(c % f));
    if (c > cmax)
      cmp("commas on other link", 10'(cmax), 10'(c));
    if (ils > 0)
    begin
      // K28.0 is balanced, so it takes the disparity left by the last comma
      cmp("align start", q[c - 1] == 10'h0fa ? 10'h30b : 10'h0f4, q[c]);
      cmp("align octet", 10'h101, {1'b0, dec(q[c + 1])});
      cmp("align end", 10'h001, {9'h000, q[c + ils - 1] inside {10'h0f3, 10'h30c}});
      c += ils;
    end
    for (int i = c; i < q.size(); i++)
    begin
      k3 = q[i] inside {10'h0f3, 10'h30c};
      k = k3 || q[i] inside {10'h0f8, 10'h307};
      // Multiframe is 16 frames of two octets or 8 of four, counted from data start
      mfe = ils > 0 && (i - c) / f % (32 / f) == 32 / f - 1;
      d = dec(q[i]);
      o = k ? (scrambler_on ? (k3 ? 8'h7c : 8'hfc) : prev[l]) : d[7:0];
      cmp("code valid", 10'h001, {9'h000, k | d[8]});
      for (int j = 7; j >= 0; j--)
        if (scrambler_on)
        begin
          b = o[j] ^ st[l][13] ^ st[l][14];
          st[l] = {st[l][13:0], o[j]};
          o[j] = b;
        end
      if (i % f == f - 1)
      begin
        if (!scrambler_on)
        begin
          em = {8'h00, mfe, !mfe} & {10{expq[l][i] == prev[l]}};
          cmp("frame end mark", em, {8'h00, k3, k && !k3});
        end
        prev[l] = expq[l][i];
      end
      else
        cmp("mid frame mark", 10'h000, {9'h000, k});
      cmp("octet", {2'h0, expq[l][i]}, {2'h0, o});
    end
  endtask
  task automatic run(input logic [1:0] mode, input logic [1:0] rs, input int n, input bit dup,
    input bit stl, input int amax, input int bmax);
    int f;
    logic rdy;
    cslt_pkg::cslt_pair_t p;
    f = (mode == cslt_pkg::MODE_ONE_LANE) ? 4 : 2;
    @(posedge clk);
    resync <= rs;
    wr(cslt_pkg::REG_QUICK_CFG, {6'h00, mode});
    @(posedge clk);
    resync <= 2'h0;
    cslt_rx_model_i.qa.delete();
    cslt_rx_model_i.qb.delete();
    pq.delete();
    expq[0].delete();
    expq[1].delete();
    for (int i = 0; i < n; i++)
    begin
      p = mk(dup ? i / 3 : i);
      pq.push_back(p);
      expq[0].push_back(p.smp_a[13:6]);
      expq[0].push_back({p.smp_a[5:0], p.ovr_a, 1'b0});
      expq[2 / f].push_back(p.smp_b[13:6]);
      expq[2 / f].push_back({p.smp_b[5:0], p.ovr_b, 1'b0});
    end
    stall <= stl;
    fork
      begin
        foreach (pq[i])
        begin
          in_valid <= 1'b1;
          in_pair <= pq[i];
          do
          begin
            @(negedge clk);
            rdy = in_ready;
            @(posedge clk);
          end while (!rdy);
        end
        in_valid <= 1'b0;
      end
      if (stl)
      begin
        // The two-entry buffer must refuse while the receiver stalls
        repeat (30) @(posedge clk);
        #1 cmp("in_ready", 10'h000, {9'h000, in_ready});
        stall <= 1'b0;
        slow <= 1'b1;
      end
    join
    for (int w = 0; w < 3000 && cslt_rx_model_i.qa.size() < f * n; w++)
      @(posedge clk);
    slow <= 1'b0;
    cmp("symbols lane a", 10'(f * n), 10'(cslt_rx_model_i.qa.size()));
    cmp("symbols lane b", 10'(f * n), 10'(cslt_rx_model_i.qb.size()));
    chk(0, f, amax);
    chk(1, f, bmax);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(cslt_pkg::REG_QUICK_CFG, cslt_pkg::QUICK_CFG_RST);
    rd(cslt_pkg::REG_LINK_CTL1, cslt_pkg::LINK_CTL1_RST);
    rd(cslt_pkg::REG_LINK_CTL2, cslt_pkg::LINK_CTL2_RST);
    rd(cslt_pkg::REG_SCR_LANE, cslt_pkg::SCR_LANE_RST);
    wr(8'h70, 8'h5a);
    rd(8'h70, 8'h00);
    wr(cslt_pkg::REG_LINK_CTL1, 8'h40);
    rd(cslt_pkg::REG_LINK_CTL1, 8'h40);
    run(2'h0, 2'h3, 12, 0, 0, 99, 99);
    run(2'h0, 2'h0, 10, 1, 0, 0, 0);
    run(2'h0, 2'h2, 12, 0, 0, 0, 99);
    run(2'h1, 2'h3, 12, 0, 0, 99, 99);
    run(2'h1, 2'h2, 12, 0, 0, 0, 0);
    run(2'h2, 2'h3, 12, 0, 0, 99, 99);
    wr(cslt_pkg::REG_LINK_CTL1, 8'h4c);
    ils = 128;
    run(2'h0, 2'h3, 120, 1, 0, 99, 99);
    ils = 0;
    wr(cslt_pkg::REG_LINK_CTL1, 8'h40);
    wr(cslt_pkg::REG_SCR_LANE, 8'h80);
    rd(cslt_pkg::REG_SCR_LANE, 8'h80);
    scrambler_on = 1'b1;
    run(2'h0, 2'h3, 12, 0, 0, 99, 99);
    scrambler_on = 1'b0;
    wr(cslt_pkg::REG_SCR_LANE, 8'h00);
    wr(cslt_pkg::REG_LINK_CTL2, 8'h10);
    diff_kill <= 1'b1;
    run(2'h0, 2'h0, 8, 0, 0, 0, 0);
    diff_kill <= 1'b0;
    wr(cslt_pkg::REG_LINK_CTL2, 8'h00);
    run(2'h0, 2'h0, 12, 0, 1, 0, 0);
    stop_test();
  end
endmodule
`default_nettype wire
